// ---- src/jvpw_err_regs.vh ----
// Register map, field positions, codes and timing constants of the error/delay block
`ifndef JVPW_ERR_REGS_VH
`define JVPW_ERR_REGS_VH

// Byte offsets on the register bus
`define JVPW_OFS_DELAY 8'h00
`define JVPW_OFS_CTRL1 8'h04
`define JVPW_OFS_CTRL2 8'h08
`define JVPW_OFS_SVR 8'h0C
`define JVPW_OFS_DATA 8'h10

// Delay configuration fields and reset value
`define JVPW_DLY_XCVR_BIT 7
`define JVPW_DLY_RX_POLARITY_BIT_BIT 6
`define JVPW_DLY_OFS_MSB 3
`define JVPW_DLY_OFS_LSB 0
`define JVPW_DLY_RESET 8'h47

// Control fields
`define JVPW_CTRL1_IE_BIT 1
`define JVPW_CTRL2_TEOD_BIT 0

// State vector codes
`define JVPW_SV_NONE 8'h00
`define JVPW_SV_TXEMPTY 8'h0C
`define JVPW_SV_LOA 8'h14
`define JVPW_SV_CRC 8'h18
`define JVPW_SV_INVALID 8'h1C

// CRC
`define JVPW_CRC_INIT 8'hFF
`define JVPW_CRC_POLY 8'h1D
`define JVPW_CRC_RESIDUE 8'hC4

// Symbol codes from the receive decoder
`define JVPW_RX_ZERO 3'h0
`define JVPW_RX_ONE 3'h1
`define JVPW_RX_SOF 3'h2
`define JVPW_RX_EOD 3'h3
`define JVPW_RX_EOF 3'h4
`define JVPW_RX_BREAK 3'h5
`define JVPW_RX_INVALID 3'h6

// Symbol codes to the transmit encoder
`define JVPW_TX_SOF 2'h0
`define JVPW_TX_ZERO 2'h1
`define JVPW_TX_ONE 2'h2
`define JVPW_TX_EOD 2'h3

// Transceiver delay timing
`define JVPW_DELAY_MIN_US 5'h09
// Cycles in one microsecond of the 20 MHz clock
`define JVPW_US_CYCLES 9'h014

`endif

// ---- src/jvpw_err_delay.v ----
// Error detection, block-mode transmit and transceiver delay configuration
// Behaviour
// - Block messages of any length are sent
// - Own-message error stops drive, reports 1C
// - Transmission error raises interrupt when enabled
// - Receive residue not C4 flags code 18
// - CRC error interrupts, then hunt for SOF
// - Invalid symbol: 1C receiving, 14 transmitting
// - Invalid stays pending behind lost arbitration
// - EOD/EOF mid-byte is framing error 1C
// - Active symbol while sending EOD: framing
// - Framing error interrupts, waits for SOF
// - Never start while bus held active
// - Shorted low: SOF unseen, abort, stay idle
// - Recovers after fault without reset
// - BREAK while receiving or sending gives 1C, read clears, idle then SOF
// - No BREAK is ever transmitted
// - Noise during own transmission aborts at once
// - Delay 16 us default, 9 to 24
// - Delay register written once, always readable
// - Transceiver select: 1 on-chip, 0 external
// - Polarity 1 passes receive, 0 inverts
// - Offset code maps to 9 plus code us
// - Interrupt enable gates every request
// - Tx-empty once shadow moved to shifter
`include "jvpw_err_regs.vh"

module jvpw_err_delay (
   input wire ref_clk,
   input wire rst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire rxPin,
   output wire rxLevel,
   input wire rxSymStrobe,
   input wire [2:0] rxSymCode,
   input wire busIdle,
   output wire txReq,
   output reg [1:0] txSym,
   input wire txSymDone,
   output wire txDrive,
   output wire xcvrSelect,
   output wire [3:0] delayOffset,
   output wire [4:0] delayUs,
   output wire [8:0] delayCycles,
   output wire irq
);

   localparam [4:0] TX_IDLE = 5'b00001;
   localparam [4:0] TX_SOF = 5'b00010;
   localparam [4:0] TX_DATA = 5'b00100;
   localparam [4:0] TX_CRC = 5'b01000;
   localparam [4:0] TX_EOD = 5'b10000;

   function [7:0] crcBit;
      input [7:0] crc;
      input b;
      begin
         crcBit = {crc[6:0], 1'b0} ^ ((crc[7] ^ b) ? `JVPW_CRC_POLY : 8'h00);
      end
   endfunction

   reg [7:0] delayCfg_r;
   reg delayLocked_r;
   reg irqEnable_r;
   reg teod_r;
   reg [7:0] shadow_r;
   reg shadowFull_r;
   reg [7:0] txShift_r;
   reg [2:0] txBitCnt_r;
   reg [7:0] txCrc_r;
   reg [4:0] txState_r;
   reg sofSeen_r;
   reg rxSync1_r;
   reg rxSync2_r;
   reg rxHunt_r;
   reg rxIdleWait_r;
   reg [2:0] rxBitCnt_r;
   reg [7:0] rxShift_r;
   reg [7:0] rxByte_r;
   reg [7:0] rxCrc_r;
   reg loaPend_r;
   reg crcPend_r;
   reg invPend_r;

   // Bus access decode
   wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wrLow = busReq & wb_we_i & wb_sel_i[0];
   wire svRead = busReq & ~wb_we_i & (wb_adr_i == `JVPW_OFS_SVR);
   wire wrDelay = wrLow & (wb_adr_i == `JVPW_OFS_DELAY);
   wire wrCtrl1 = wrLow & (wb_adr_i == `JVPW_OFS_CTRL1);
   wire wrCtrl2 = wrLow & (wb_adr_i == `JVPW_OFS_CTRL2);
   wire wrData = wrLow & (wb_adr_i == `JVPW_OFS_DATA);

   // Delay configuration outputs
   wire rx_polarity_bit = delayCfg_r[`JVPW_DLY_RX_POLARITY_BIT_BIT];
   assign xcvrSelect = delayCfg_r[`JVPW_DLY_XCVR_BIT];
   assign delayOffset = delayCfg_r[`JVPW_DLY_OFS_MSB:`JVPW_DLY_OFS_LSB];
   assign delayUs = {1'b0, delayOffset} + `JVPW_DELAY_MIN_US;
   assign delayCycles = delayUs * `JVPW_US_CYCLES;

   // Receive pin through two flops, then polarity
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rxSync1_r <= 1'b0;
         rxSync2_r <= 1'b0;
      end else begin
         rxSync1_r <= rxPin;
         rxSync2_r <= rxSync1_r;
      end
   end
   assign rxLevel = rx_polarity_bit ? rxSync2_r : ~rxSync2_r;

   // Transmit side
   wire txBusy = ~txState_r[0];
   assign txReq = txBusy;
   assign txDrive = txBusy;

   wire rxSof = rxSymStrobe & (rxSymCode == `JVPW_RX_SOF);
   wire rxEnd = rxSymStrobe & ((rxSymCode == `JVPW_RX_EOD) | (rxSymCode == `JVPW_RX_EOF));
   wire rxBit = rxSymStrobe & ((rxSymCode == `JVPW_RX_ZERO) | (rxSymCode == `JVPW_RX_ONE));
   wire rxBreak = rxSymStrobe & (rxSymCode == `JVPW_RX_BREAK);
   wire rxInvalid = rxSymStrobe & (rxSymCode == `JVPW_RX_INVALID);
   wire rxListen = ~rxHunt_r | txBusy;

   // Error events
   wire symErr = rxInvalid & rxListen;
   wire frameErr = rxEnd & ~rxHunt_r & (rxBitCnt_r != 3'h0);
   wire eodClash = (txState_r == TX_EOD) & (rxBit | rxSof);
   wire breakErr = rxBreak & rxListen;
   wire sofMiss = (txState_r == TX_SOF) & txSymDone & ~sofSeen_r & ~rxSof;
   wire crcErr = rxEnd & ~rxHunt_r & (rxBitCnt_r == 3'h0)
      & (rxSymCode == `JVPW_RX_EOD) & (rxCrc_r != `JVPW_CRC_RESIDUE);

   wire setLoa = symErr & txBusy;
   wire setInv = symErr | frameErr | eodClash | breakErr | sofMiss;
   wire setCrc = crcErr;
   wire txAbort = txBusy & (symErr | breakErr | eodClash | sofMiss
      | (rxEnd & (rxBitCnt_r != 3'h0)));

   // Tx-empty visible only while a message is going and before end is asked
   wire txEmpty = txBusy & ~shadowFull_r & ~teod_r;

   // Presented state vector, highest priority first
   reg [7:0] svCode;
   always @* begin
      if (loaPend_r) begin
         svCode = `JVPW_SV_LOA;
      end else if (crcPend_r) begin
         svCode = `JVPW_SV_CRC;
      end else if (invPend_r) begin
         svCode = `JVPW_SV_INVALID;
      end else if (txEmpty) begin
         svCode = `JVPW_SV_TXEMPTY;
      end else begin
         svCode = `JVPW_SV_NONE;
      end
   end

   assign irq = irqEnable_r & (loaPend_r | crcPend_r | invPend_r | txEmpty);

   // Next symbol for the encoder; no BREAK code exists here
   always @* begin
      if (txState_r == TX_SOF) begin
         txSym = `JVPW_TX_SOF;
      end else if (txState_r == TX_EOD) begin
         txSym = `JVPW_TX_EOD;
      end else begin
         txSym = txShift_r[7] ? `JVPW_TX_ONE : `JVPW_TX_ZERO;
      end
   end

   // Register bus slave
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= busReq;
         if (busReq & ~wb_we_i) begin
            if (wb_adr_i == `JVPW_OFS_DELAY) begin
               wb_dat_o <= {24'h000000, delayCfg_r};
            end else if (wb_adr_i == `JVPW_OFS_CTRL1) begin
               wb_dat_o <= {30'h0, irqEnable_r, 1'b0};
            end else if (wb_adr_i == `JVPW_OFS_CTRL2) begin
               wb_dat_o <= {31'h0, teod_r};
            end else if (wb_adr_i == `JVPW_OFS_SVR) begin
               wb_dat_o <= {24'h000000, svCode};
            end else if (wb_adr_i == `JVPW_OFS_DATA) begin
               wb_dat_o <= {24'h000000, rxByte_r};
            end else begin
               wb_dat_o <= 32'h00000000;
            end
         end
      end
   end

   // Configuration registers
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         delayCfg_r <= `JVPW_DLY_RESET;
         delayLocked_r <= 1'b0;
         irqEnable_r <= 1'b0;
      end else begin
         if (wrDelay & ~delayLocked_r) begin
            delayCfg_r <= {wb_dat_i[7:6], 2'b00, wb_dat_i[3:0]};
            delayLocked_r <= 1'b1;
         end
         if (wrCtrl1) begin
            irqEnable_r <= wb_dat_i[`JVPW_CTRL1_IE_BIT];
         end
      end
   end

   // Pending flags: a new event wins over the read that clears it
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         loaPend_r <= 1'b0;
         crcPend_r <= 1'b0;
         invPend_r <= 1'b0;
      end else begin
         loaPend_r <= setLoa | (loaPend_r & ~(svRead & (svCode == `JVPW_SV_LOA)));
         crcPend_r <= setCrc | (crcPend_r & ~(svRead & (svCode == `JVPW_SV_CRC)));
         invPend_r <= setInv | (invPend_r & ~(svRead & (svCode == `JVPW_SV_INVALID)));
      end
   end

   // Shadow byte and end-of-data request
   wire txLoad = (txState_r == TX_IDLE) & shadowFull_r & busIdle & ~rxLevel;
   wire txByteDone = (txState_r == TX_DATA) & txSymDone & (txBitCnt_r == 3'h7);
   wire shadowTake = txLoad | (txByteDone & shadowFull_r & ~txAbort);

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         shadow_r <= 8'h00;
         shadowFull_r <= 1'b0;
         teod_r <= 1'b0;
      end else begin
         if (wrData) begin
            shadow_r <= wb_dat_i[7:0];
            shadowFull_r <= 1'b1;
         end else if (txAbort) begin
            shadowFull_r <= 1'b0;
         end else if (shadowTake) begin
            shadowFull_r <= 1'b0;
         end
         if (wrCtrl2 & wb_dat_i[`JVPW_CTRL2_TEOD_BIT]) begin
            teod_r <= 1'b1;
         end else if (txAbort | ((txState_r == TX_EOD) & txSymDone)) begin
            teod_r <= 1'b0;
         end
      end
   end

   // Transmit state machine
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         txState_r <= TX_IDLE;
         txShift_r <= 8'h00;
         txBitCnt_r <= 3'h0;
         txCrc_r <= `JVPW_CRC_INIT;
         sofSeen_r <= 1'b0;
      end else if (txAbort) begin
         txState_r <= TX_IDLE;
         sofSeen_r <= 1'b0;
      end else begin
         case (txState_r)
            TX_IDLE: begin
               if (txLoad) begin
                  txShift_r <= shadow_r;
                  txBitCnt_r <= 3'h0;
                  txCrc_r <= `JVPW_CRC_INIT;
                  sofSeen_r <= 1'b0;
                  txState_r <= TX_SOF;
               end
            end
            TX_SOF: begin
               if (rxSof) begin
                  sofSeen_r <= 1'b1;
               end
               if (txSymDone) begin
                  txState_r <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (txSymDone) begin
                  txCrc_r <= crcBit(txCrc_r, txShift_r[7]);
                  txBitCnt_r <= txBitCnt_r + 3'h1;
                  if (txBitCnt_r == 3'h7) begin
                     if (shadowFull_r) begin
                        txShift_r <= shadow_r;
                     end else begin
                        txShift_r <= ~crcBit(txCrc_r, txShift_r[7]);
                        txState_r <= TX_CRC;
                     end
                  end else begin
                     txShift_r <= {txShift_r[6:0], 1'b0};
                  end
               end
            end
            TX_CRC: begin
               if (txSymDone) begin
                  txBitCnt_r <= txBitCnt_r + 3'h1;
                  txShift_r <= {txShift_r[6:0], 1'b0};
                  if (txBitCnt_r == 3'h7) begin
                     txState_r <= TX_EOD;
                  end
               end
            end
            TX_EOD: begin
               if (txSymDone) begin
                  txState_r <= TX_IDLE;
               end
            end
            default: begin
               txState_r <= TX_IDLE;
            end
         endcase
      end
   end

   // Receive framing, CRC check and SOF hunt
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rxHunt_r <= 1'b1;
         rxIdleWait_r <= 1'b0;
         rxBitCnt_r <= 3'h0;
         rxShift_r <= 8'h00;
         rxByte_r <= 8'h00;
         rxCrc_r <= `JVPW_CRC_INIT;
      end else begin
         if (rxBreak) begin
            rxHunt_r <= 1'b1;
            rxIdleWait_r <= 1'b1;
         end else if (rxIdleWait_r) begin
            if (busIdle) begin
               rxIdleWait_r <= 1'b0;
            end
         end else if (rxSof) begin
            rxHunt_r <= 1'b0;
            rxBitCnt_r <= 3'h0;
            rxCrc_r <= `JVPW_CRC_INIT;
         end else if (~rxHunt_r) begin
            if (symErr | frameErr | eodClash | setCrc) begin
               rxHunt_r <= 1'b1;
            end else if (rxEnd) begin
               rxHunt_r <= 1'b1;
            end else if (rxBit) begin
               rxShift_r <= {rxShift_r[6:0], rxSymCode[0]};
               rxCrc_r <= crcBit(rxCrc_r, rxSymCode[0]);
               rxBitCnt_r <= rxBitCnt_r + 3'h1;
               if (rxBitCnt_r == 3'h7) begin
                  rxByte_r <= {rxShift_r[6:0], rxSymCode[0]};
               end
            end
         end
      end
   end

endmodule // jvpw_err_delay

// ---- tb/jvpw_err_delay_props.sv ----
// Port checker for the error and delay block
`include "jvpw_err_regs.vh"
module jvpw_err_delay_props (
   input wire ref_clk,
   input wire rst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire rxLevel,
   input wire rxSymStrobe,
   input wire [2:0] rxSymCode,
   input wire busIdle,
   input wire txReq,
   input wire [1:0] txSym,
   input wire txSymDone,
   input wire txDrive,
   input wire [3:0] delayOffset,
   input wire [4:0] delayUs,
   input wire [8:0] delayCycles
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence badSym;
      txReq && rxSymStrobe && (rxSymCode == `JVPW_RX_INVALID || rxSymCode == `JVPW_RX_BREAK);
   endsequence
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_DAT_HIGH: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   AST_DLY_US: assert property (delayUs == 5'h09 + delayOffset)
      else $error("delay not nine plus offset");
   AST_DLY_CYC: assert property (delayCycles == delayUs * 9'h014)
      else $error("delay cycles wrong");
   AST_DRIVE: assert property (txReq == txDrive)
      else $error("drive differs from request");
   AST_IDLE_START: assert property ($rose(txReq) |-> $past(busIdle) && !$past(rxLevel))
      else $error("start on busy bus");
   AST_SOF_FIRST: assert property ($rose(txReq) |-> txSym == `JVPW_TX_SOF)
      else $error("message not begun with SOF");
   AST_SYM_HOLD: assert property (txReq && !txSymDone |=> !txReq || $stable(txSym))
      else $error("symbol changed before done");
   AST_ABORT: assert property (badSym |=> !txReq)
      else $error("no abort on bad symbol");
endmodule // jvpw_err_delay_props
bind jvpw_err_delay jvpw_err_delay_props u_props (.ref_clk(ref_clk), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .rxLevel(rxLevel), .rxSymStrobe(rxSymStrobe), .rxSymCode(rxSymCode), .busIdle(busIdle),
   .txReq(txReq), .txSym(txSym), .txSymDone(txSymDone), .txDrive(txDrive),
   .delayOffset(delayOffset), .delayUs(delayUs), .delayCycles(delayCycles));

// ---- tb/jvpw_bus_model.sv ----
// Bus side model: symbol encoder, decoder echo and fault injection
module jvpw_bus_model (
   input wire ref_clk,
   input wire rst,
   input wire txReq,
   input wire [1:0] txSym,
   input wire txDrive,
   input wire [1:0] mode,
   input wire held,
   output wire rxPin,
   output wire rxSymStrobe,
   output wire [2:0] rxSymCode,
   output wire busIdle,
   output logic txSymDone
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] cnt;
   logic [2:0] junk;
   logic [2:0] injCode = 3'h0;
   logic injStb = 1'b0;
   logic echoStb;
   logic [31:0] sent;
   int nBits;
   wire [2:0] echoCode = txSym == 2'h0 ? 3'h2 : txSym == 2'h3 ? 3'h3 :
      mode == 2'd1 ? 3'h6 : {2'b0, txSym == 2'h2};
   // Mode 2 ground short hides own drive, held is supply short
   assign rxPin = held | (txDrive & mode != 2'd2);
   assign busIdle = !held;
   assign rxSymStrobe = echoStb | injStb;
   // Code lines wander outside strobes
   assign rxSymCode = echoStb ? echoCode : injStb ? injCode : junk;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt <= 3'h0;
         junk <= 3'h0;
         echoStb <= 1'b0;
         txSymDone <= 1'b0;
         sent <= 32'h0;
         nBits <= 0;
      end else begin
         junk <= junk + 3'h3;
         echoStb <= txReq && cnt == 3'h1 && mode != 2'd2;
         txSymDone <= txReq && cnt == 3'h3;
         cnt <= txReq && cnt != 3'h4 ? cnt + 3'h1 : 3'h0;
         if (txReq && cnt == 3'h3 && txSym[0] != txSym[1]) begin
            sent <= {sent[30:0], txSym == 2'h2};
            nBits <= nBits + 1;
         end
      end
   end
   task automatic sendSym(input logic [2:0] c);
      @(posedge ref_clk);
      injStb <= 1'b1;
      injCode <= c;
      @(posedge ref_clk);
      injStb <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask
endmodule // jvpw_bus_model

// ---- tb/jvpw_err_delay_tb.sv ----
// Self-checking bench for the error and delay block
`include "jvpw_err_regs.vh"
module jvpw_err_delay_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] DL = `JVPW_OFS_DELAY, C1 = `JVPW_OFS_CTRL1;
   localparam logic [7:0] C2 = `JVPW_OFS_CTRL2;
   localparam logic [7:0] SV = `JVPW_OFS_SVR, DT = `JVPW_OFS_DATA;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [1:0] mode = 2'd0;
   logic held = 1'b0;
   logic [31:0] rd;
   int nMismatch = 0;
   int numChecks = 0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, rxPin, rxLevel, rxSymStrobe, busIdle, txReq;
   wire txSymDone, txDrive, xcvrSelect, irq;
   wire [2:0] rxSymCode;
   wire [1:0] txSym;
   wire [3:0] delayOffset;
   wire [4:0] delayUs;
   wire [8:0] delayCycles;
   always #25 ref_clk = ~ref_clk;
   jvpw_err_delay dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxPin(rxPin), .rxLevel(rxLevel),
      .rxSymStrobe(rxSymStrobe), .rxSymCode(rxSymCode), .busIdle(busIdle), .txReq(txReq),
      .txSym(txSym), .txSymDone(txSymDone), .txDrive(txDrive), .xcvrSelect(xcvrSelect),
      .delayOffset(delayOffset), .delayUs(delayUs), .delayCycles(delayCycles), .irq(irq));
   jvpw_bus_model bus (.ref_clk(ref_clk), .rst(rst), .txReq(txReq), .txSym(txSym),
      .txDrive(txDrive), .mode(mode), .held(held), .rxPin(rxPin), .rxSymStrobe(rxSymStrobe),
      .rxSymCode(rxSymCode), .busIdle(busIdle), .txSymDone(txSymDone));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wbAcc(input logic we, input logic [7:0] adr, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'h1;
      wb_dat_i <= {24'h0, d};
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 50) begin
         nMismatch++;
         $display("Error at %0t: no bus acknowledge", $time);
      end
   endtask
   task automatic chkReg(input logic [7:0] adr, input logic [7:0] exp);
      wbAcc(1'b0, adr, 8'h00);
      chk(rd, {24'h0, exp});
   endtask
   task automatic waitTx(input logic lvl);
      int n;
      n = 0;
      while (txReq !== lvl && n < 500) begin
         @(posedge ref_clk);
         n++;
      end
      chk(txReq, lvl);
   endtask
   function automatic logic [7:0] crcOf(input logic [15:0] d);
      logic [7:0] c;
      c = 8'hFF;
      for (int i = 15; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1D : 8'h00);
      return ~c;
   endfunction
   task automatic rxFrame(input logic sof, input logic [23:0] v, input int n,
         input logic [2:0] e);
      if (sof) bus.sendSym(`JVPW_RX_SOF);
      for (int i = 0; i < n; i++) bus.sendSym({2'b0, v[23 - i]});
      bus.sendSym(e);
   endtask
   task automatic conclude;
      $display("Checks %0d mismatches %0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      nMismatch++;
      $display("Error at %0t: watchdog expired", $time);
      conclude;
   end
   initial begin
      int n;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      chkReg(DL, 8'h47);
      chk(delayCycles, 32'h140);
      chk(xcvrSelect, 32'h0);
      chk(rxLevel, 32'h0);
      wbAcc(1'b1, DL, 8'h40);
      wbAcc(1'b1, DL, 8'h8F);
      chkReg(DL, 8'h40);
      chk(delayUs, 9);
      chkReg(8'h1C, 8'h00);
      wbAcc(1'b1, C1, 8'h02);
      mode <= 2'd2;
      wbAcc(1'b1, DT, 8'h11);
      waitTx(1'b1);
      waitTx(1'b0);
      chk(irq, 1);
      chkReg(SV, 8'h1C);
      repeat (100) @(posedge ref_clk);
      chk(txReq, 0);
      mode <= 2'd0;
      held <= 1'b1;
      wbAcc(1'b1, DT, 8'hA5);
      repeat (100) @(posedge ref_clk);
      chk(txReq, 0);
      held <= 1'b0;
      waitTx(1'b1);
      n = 0;
      do begin
         wbAcc(1'b0, SV, 8'h00);
         n++;
      end while (rd !== 32'h0C && n < 20);
      chk(rd, 32'h0C);
      wbAcc(1'b1, DT, 8'h3C);
      wbAcc(1'b1, C2, 8'h01);
      chkReg(C2, 8'h01);
      waitTx(1'b0);
      chkReg(C2, 8'h00);
      chk(bus.nBits, 24);
      chk(bus.sent[23:0], {16'hA53C, crcOf(16'hA53C)});
      chkReg(SV, 8'h00);
      mode <= 2'd1;
      wbAcc(1'b1, DT, 8'h77);
      waitTx(1'b1);
      waitTx(1'b0);
      chk(irq, 1);
      chkReg(SV, 8'h14);
      chkReg(SV, 8'h1C);
      chkReg(SV, 8'h00);
      mode <= 2'd0;
      rxFrame(1'b1, {16'h55AA, crcOf(16'h55AA)}, 24, `JVPW_RX_EOD);
      chkReg(SV, 8'h00);
      chkReg(DT, crcOf(16'h55AA));
      rxFrame(1'b1, {16'h55AA, ~crcOf(16'h55AA)}, 24, `JVPW_RX_EOD);
      chk(irq, 1);
      chkReg(SV, 8'h18);
      rxFrame(1'b0, 24'h0, 3, `JVPW_RX_EOD);
      chkReg(SV, 8'h00);
      wbAcc(1'b1, C1, 8'h00);
      rxFrame(1'b1, 24'h0, 3, `JVPW_RX_EOF);
      chk(irq, 0);
      chkReg(SV, 8'h1C);
      rxFrame(1'b1, 24'h0, 2, `JVPW_RX_BREAK);
      chkReg(SV, 8'h1C);
      chkReg(SV, 8'h00);
      rxFrame(1'b0, 24'h0, 5, `JVPW_RX_EOD);
      chkReg(SV, 8'h00);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      wbAcc(1'b1, DL, 8'h0F);
      chk(delayUs, 32'h18);
      chk(delayOffset, 32'hF);
      repeat (3) @(posedge ref_clk);
      chk(rxLevel, 1);
      conclude;
   end
endmodule // jvpw_err_delay_tb
